// ---- hw/remappable_pin_select_map.sv ----
// Remappable pin select map: fault input routing and output function mapping
`timescale 1ns/1ps
`default_nettype none

module remappable_pin_select_map
#(
   // Widths and counts
   parameter int func_count = pin_map_pkg::num_func,
   parameter int pin_count = pin_map_pkg::num_pins,
   parameter int out_pin_count = 6
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Peripheral side
   input wire logic [func_count-1:0] periph_out_func,
   input wire logic [pin_count-1:0] remappable_pin,
   output logic [out_pin_count-1:0] remappable_pin_out,
   output logic pwm_fault_input_seven,
   output logic pwm_fault_input_eight
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [3:0] be, input logic [15:0] mask);
      logic [15:0] v;
      v = old;
      if (be[0]) v[7:0] = wd[7:0];
      if (be[1]) v[15:8] = wd[15:8];
      merge = v & mask;
   endfunction

   // Codes past the last pin read as ground, the same as code zero
   function automatic logic pick_pin(input logic [7:0] sel,
                                     input logic [pin_count-1:0] pins);
      if (sel == pin_map_pkg::pin_sel_ground || int'(sel) >= pin_count)
         pick_pin = 1'b0;
      else
         pick_pin = pins[sel];
   endfunction

   // Picks one function number out of an output map register
   function automatic logic [pin_map_pkg::func_width-1:0] func_field(input logic [15:0] r,
                                                                  input int pos);
      func_field = r[pos +: pin_map_pkg::func_width];
   endfunction

   // Every bit of the fault select register is writable
   localparam logic [15:0] fault_map_mask = 16'hffff;

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   pin_map_pkg::regs_s regs;
   pin_map_pkg::regs_s next_regs;
   logic [31:0] next_readdata;
   logic read_done;
   logic next_read_done;
   logic read_start;

   // A read is launched on its first cycle and answered on the second, so
   // readdata comes from a flip-flop; writes never wait
   assign read_start = read & ~read_done;
   assign waitrequest = read_start;

   // ------------------------------------------------------------
   // Write path
   // ------------------------------------------------------------
   always_comb
   begin
      next_regs = regs;
      if (write)
      begin
         unique case (address)
            pin_map_pkg::fault_input_pin_select_off:
               next_regs.fault_input_pin_select = merge(regs.fault_input_pin_select,
                  writedata, byteenable, fault_map_mask);
            pin_map_pkg::output_pin_map_32_33_off:
               next_regs.output_pin_map_32_33 = merge(regs.output_pin_map_32_33,
                  writedata, byteenable, pin_map_pkg::out_map_mask);
            pin_map_pkg::output_pin_map_34_35_off:
               next_regs.output_pin_map_34_35 = merge(regs.output_pin_map_34_35,
                  writedata, byteenable, pin_map_pkg::out_map_mask);
            pin_map_pkg::output_pin_map_36_37_off:
               next_regs.output_pin_map_36_37 = merge(regs.output_pin_map_36_37,
                  writedata, byteenable, pin_map_pkg::out_map_mask);
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         regs <= '{default: pin_map_pkg::reg_reset};
      end
      else
      begin
         regs <= next_regs;
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   always_comb
   begin
      next_readdata = readdata;
      next_read_done = 1'b0;
      if (read_start)
      begin
         next_read_done = 1'b1;
         unique case (address)
            pin_map_pkg::fault_input_pin_select_off:
               next_readdata = {16'h0000, regs.fault_input_pin_select};
            pin_map_pkg::output_pin_map_32_33_off:
               next_readdata = {16'h0000, regs.output_pin_map_32_33};
            pin_map_pkg::output_pin_map_34_35_off:
               next_readdata = {16'h0000, regs.output_pin_map_34_35};
            pin_map_pkg::output_pin_map_36_37_off:
               next_readdata = {16'h0000, regs.output_pin_map_36_37};
            default:
               next_readdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         readdata <= 32'h0000_0000;
         read_done <= 1'b0;
      end
      else
      begin
         readdata <= next_readdata;
         read_done <= next_read_done;
      end
   end

   // ------------------------------------------------------------
   // Routing
   // ------------------------------------------------------------
   logic [5:0] out_func_sel_pin32;
   logic [5:0] out_func_sel_pin33;
   logic [5:0] out_func_sel_pin34;
   logic [5:0] out_func_sel_pin35;
   logic [5:0] out_func_sel_pin36;
   logic [5:0] out_func_sel_pin37;
   logic [7:0] fault_seven_pin_select;
   logic [7:0] fault_eight_pin_select;
   logic [out_pin_count-1:0] next_pin_out;
   logic next_fault_seven;
   logic next_fault_eight;

   assign out_func_sel_pin32 = func_field(regs.output_pin_map_32_33, pin_map_pkg::func_lo_pos);
   assign out_func_sel_pin33 = func_field(regs.output_pin_map_32_33, pin_map_pkg::func_hi_pos);
   assign out_func_sel_pin34 = func_field(regs.output_pin_map_34_35, pin_map_pkg::func_lo_pos);
   assign out_func_sel_pin35 = func_field(regs.output_pin_map_34_35, pin_map_pkg::func_hi_pos);
   assign out_func_sel_pin36 = func_field(regs.output_pin_map_36_37, pin_map_pkg::func_lo_pos);
   assign out_func_sel_pin37 = func_field(regs.output_pin_map_36_37, pin_map_pkg::func_hi_pos);
   assign fault_seven_pin_select = regs.fault_input_pin_select[pin_map_pkg::fault_seven_pos +: 8];
   assign fault_eight_pin_select = regs.fault_input_pin_select[pin_map_pkg::fault_eight_pos +: 8];

   always_comb
   begin
      next_pin_out[0] = periph_out_func[out_func_sel_pin32];
      next_pin_out[1] = periph_out_func[out_func_sel_pin33];
      next_pin_out[2] = periph_out_func[out_func_sel_pin34];
      next_pin_out[3] = periph_out_func[out_func_sel_pin35];
      next_pin_out[4] = periph_out_func[out_func_sel_pin36];
      next_pin_out[5] = periph_out_func[out_func_sel_pin37];
   end

   // ------------------------------------------------------------
   // Fault input routing
   // ------------------------------------------------------------
   always_comb
   begin
      next_fault_seven = pick_pin(fault_seven_pin_select, remappable_pin);
      next_fault_eight = pick_pin(fault_eight_pin_select, remappable_pin);
   end

   // ------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         remappable_pin_out <= '0;
         pwm_fault_input_seven <= 1'b0;
         pwm_fault_input_eight <= 1'b0;
      end
      else
      begin
         remappable_pin_out <= next_pin_out;
         pwm_fault_input_seven <= next_fault_seven;
         pwm_fault_input_eight <= next_fault_eight;
      end
   end

endmodule // remappable_pin_select_map

`default_nettype wire

// ---- common/pin_map_pkg.sv ----
// Package for the remappable pin select map: offsets, fields, resets and carriers
package pin_map_pkg;

   // ------------------------------------------------------------
   // Register word offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [3:0] fault_input_pin_select_off = 4'h0;
   localparam logic [3:0] output_pin_map_32_33_off = 4'h4;
   localparam logic [3:0] output_pin_map_34_35_off = 4'h8;
   localparam logic [3:0] output_pin_map_36_37_off = 4'hc;

   // ------------------------------------------------------------
   // Field layout and reset values
   // ------------------------------------------------------------
   localparam int reg_width = 16;
   localparam int pin_sel_width = 8;
   localparam int func_width = 6;
   localparam int func_lo_pos = 0;
   localparam int func_hi_pos = 8;
   localparam int fault_seven_pos = 0;
   localparam int fault_eight_pos = 8;
   localparam logic [15:0] out_map_mask = 16'h3f3f;
   localparam logic [15:0] reg_reset = 16'h0000;
   localparam logic [7:0] pin_sel_ground = 8'h00;
   localparam int num_func = 64;
   localparam int num_pins = 182;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [15:0] fault_input_pin_select;
      logic [15:0] output_pin_map_32_33;
      logic [15:0] output_pin_map_34_35;
      logic [15:0] output_pin_map_36_37;
   } regs_s;

   typedef struct packed {
      logic read;
      logic write;
      logic [3:0] address;
      logic [31:0] writedata;
   } avalon_req_s;

endpackage

// ---- verif/pin_map_monitor.sv ----
// Assertion checker for the remappable pin select map
`timescale 1ns/1ps
`default_nettype none
module pin_map_monitor
(
   // Bus side
   input wire logic clock,
   input wire logic rst,
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // Peripheral side
   input wire logic [63:0] periph_out_func,
   input wire logic [181:0] remappable_pin,
   input wire logic [5:0] remappable_pin_out,
   input wire logic pwm_fault_input_seven,
   input wire logic pwm_fault_input_eight
);
   logic [15:0] s [4];
   logic [255:0] pe;
   assign pe = {74'h0, remappable_pin[181:1], 1'b0};
   // Shadow of the register contents, unused bits dropped
   always_ff @(posedge clock)
      if (rst)
         s <= '{default: 16'h0};
      else if (write && address[1:0] == 2'h0)
      begin
         if (byteenable[0])
            s[address[3:2]][7:0] <= writedata[7:0] & (address == 4'h0 ? 8'hff : 8'h3f);
         if (byteenable[1])
            s[address[3:2]][15:8] <= writedata[15:8] & (address == 4'h0 ? 8'hff : 8'h3f);
      end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   a_pin32_route: assert property (!$past(rst) |-> remappable_pin_out[0] == $past(periph_out_func[s[1][5:0]])) else $error("pin 32");
   a_pin34_route: assert property (!$past(rst) |-> remappable_pin_out[2] == $past(periph_out_func[s[2][5:0]])) else $error("pin 34");
   a_pin35_route: assert property (!$past(rst) |-> remappable_pin_out[3] == $past(periph_out_func[s[2][13:8]])) else $error("pin 35");
   a_pin36_route: assert property (!$past(rst) |-> remappable_pin_out[4] == $past(periph_out_func[s[3][5:0]])) else $error("pin 36");
   a_pin37_route: assert property (!$past(rst) |-> remappable_pin_out[5] == $past(periph_out_func[s[3][13:8]])) else $error("pin 37");
   a_read_masked: assert property (read && !waitrequest |-> readdata == {16'h0, s[address[3:2]] & {16{address[1:0] == 2'h0}}}) else $error("read value");
   a_fault_seven: assert property (!$past(rst) |-> pwm_fault_input_seven == $past(pe[s[0][7:0]])) else $error("fault 7");
   a_fault_eight: assert property (!$past(rst) |-> pwm_fault_input_eight == $past(pe[s[0][15:8]])) else $error("fault 8");
   a_read_wait: assert property ($rose(read) |-> waitrequest ##1 !waitrequest) else $error("read wait");
   c_read_map: cover property (read && !waitrequest && address == 4'h8);
   c_write_fault: cover property (write && address == 4'h0);
   c_fault_high: cover property (pwm_fault_input_seven);
endmodule // pin_map_monitor
bind remappable_pin_select_map pin_map_monitor pin_map_monitor_i (.clock, .rst, .address, .read,
   .write, .writedata, .byteenable, .readdata, .waitrequest, .periph_out_func, .remappable_pin,
   .remappable_pin_out, .pwm_fault_input_seven, .pwm_fault_input_eight);
`default_nettype wire

// ---- verif/remappable_pin_select_map_tb.sv ----
// Self-checking testbench for the remappable pin select map
`timescale 1ns/1ps
`default_nettype none
module remappable_pin_select_map_tb;
   logic clock, rst, read, write, waitrequest, pwm_fault_input_seven, pwm_fault_input_eight;
   logic [3:0] address, byteenable;
   logic [31:0] writedata, readdata;
   logic [63:0] periph_out_func;
   logic [181:0] remappable_pin;
   logic [5:0] remappable_pin_out;
   logic [15:0] m [4];
   logic [31:0] q [$];
   int failures, checks_done;
   remappable_pin_select_map remappable_pin_select_map_i (.clock, .rst, .address, .read, .write,
      .writedata, .byteenable, .readdata, .waitrequest, .periph_out_func, .remappable_pin,
      .remappable_pin_out, .pwm_fault_input_seven, .pwm_fault_input_eight);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("failures %0d checks %0d", failures, checks_done);
      if (failures == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Holds the request until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      int n;
      @(posedge clock);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= d;
      byteenable <= be;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (waitrequest && n < 50);
      if (waitrequest)
      begin
         failures++;
         test_done();
      end
      read <= 1'b0;
      write <= 1'b0;
   endtask
   always @(posedge clock)
      if (read && !waitrequest && q.size() > 0)
         chk(readdata, q.pop_front());
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial
   begin
      logic [3:0] a, be;
      logic [15:0] d;
      logic [7:0] f7, f8;
      rst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 4'h0;
      writedata = 32'h0;
      byteenable = 4'h0;
      periph_out_func = 64'h0;
      remappable_pin = 182'h0;
      m = '{default: 16'h0};
      failures = 0;
      checks_done = 0;
      void'($urandom(32'h3d9c54b7));
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         q.push_back(32'h0);
         bus(1'b0, 4'(i * 4), 32'h0, 4'h3);
      end
      for (int i = 0; i < 40; i++)
      begin
         a = (i % 9 == 8) ? 4'h2 : 4'($urandom_range(3) * 4);
         d = 16'($urandom);
         be = 4'($urandom);
         if (i < 3)
         begin
            a = 4'h0;
            d = {8'hb6, 8'(i * 8'hb5)};
            be = 4'h3;
         end
         bus(1'b1, a, {16'($urandom), d}, be);
         if (a[1:0] == 2'h0)
         begin
            if (be[0])
               m[a[3:2]][7:0] = d[7:0];
            if (be[1])
               m[a[3:2]][15:8] = d[15:8];
            m[a[3:2]] = m[a[3:2]] & (a == 4'h0 ? 16'hffff : pin_map_pkg::out_map_mask);
         end
         q.push_back((a[1:0] == 2'h0) ? {16'h0, m[a[3:2]]} : 32'h0);
         bus(1'b0, a, 32'h0, 4'h3);
         periph_out_func <= {$urandom, $urandom};
         remappable_pin <= 182'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
         @(posedge clock);
         @(negedge clock);
         f7 = m[0][7:0];
         f8 = m[0][15:8];
         chk(remappable_pin_out[0], periph_out_func[m[1][5:0]]);
         chk(remappable_pin_out[1], periph_out_func[m[1][13:8]]);
         chk(remappable_pin_out[2], periph_out_func[m[2][5:0]]);
         chk(remappable_pin_out[3], periph_out_func[m[2][13:8]]);
         chk(remappable_pin_out[4], periph_out_func[m[3][5:0]]);
         chk(remappable_pin_out[5], periph_out_func[m[3][13:8]]);
         chk(pwm_fault_input_seven, (f7 == 0 || f7 > 181) ? 1'b0 : remappable_pin[f7]);
         chk(pwm_fault_input_eight, (f8 == 0 || f8 > 181) ? 1'b0 : remappable_pin[f8]);
      end
      test_done();
   end
endmodule // remappable_pin_select_map_tb
`default_nettype wire
